// ===== design/plcd_decoder.sv
// pulse length command decoder: top level
// assumes one 10 MHz clock, command line synchronous to it, motor handled outside
//
// Behaviour
// - Pulses of 2, 5 and 8 s start a stroke of pump one, pump two, or both.
// - A 12 s pulse starts the fill sequence.
// - A 14 s pulse acknowledges an error and is the longest valid command.
// - A pulse outside every tolerance window causes no action.
// - A pulse high for more than 15 s is ignored.
// - Status goes to the controller only as levels on one output line.
// - After power up a self-check runs, then the device waits for commands.
// - The product variant decides which commands are accepted.
// - Distinct status patterns show conditions such as an empty cartridge.
// - Status is held steadily high while ready.
// - A valid pulse starts the run at its falling edge with status low until done.
// - Pulses are ignored until more than 3 s after a successful run.
`timescale 1ns/10ps
module plcd_decoder
  import plcd_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYCLES
) (
  input  wire logic          I_CLOCK,
  input  wire logic          I_RESET_N,
  input  wire logic          I_CMD_LINE,
  input  wire logic [2:0]    I_VARIANT,
  input  wire logic          I_SELFTEST_FAIL,
  input  wire logic          I_CARTRIDGE_EMPTY,
  input  wire logic          I_RUN_DONE,
  input  wire logic          I_RUN_ERROR,
  output logic               O_STATUS,
  output logic               O_RUN_START,
  output logic               O_RUN_PUMP_ONE,
  output logic               O_RUN_PUMP_TWO,
  output logic               O_RUN_FILL,
  output logic               O_ERROR_ACK
);

  // ----------------------------------------------------------------------
  // decoding functions
  // ----------------------------------------------------------------------
  function automatic logic in_window(input logic [LEN_W-1:0] len,
                                     input logic [LEN_W-1:0] nom);
    in_window = (len >= nom - TOL_TICKS) && (len <= nom + TOL_TICKS);
  endfunction

  function automatic plcd_cmd_t classify(input logic [LEN_W-1:0] len);
    classify = CMD_NONE;
    if (len > LIMIT_TICKS)                classify = CMD_NONE;
    else if (in_window(len, NOM_PUMP_ONE)) classify = CMD_PUMP_ONE;
    else if (in_window(len, NOM_PUMP_TWO)) classify = CMD_PUMP_TWO;
    else if (in_window(len, NOM_BOTH))     classify = CMD_BOTH;
    else if (in_window(len, NOM_FILL))     classify = CMD_FILL;
    else if (in_window(len, NOM_ACK))      classify = CMD_ACK;
  endfunction

  function automatic logic allowed(input plcd_cmd_t c, input logic [2:0] v);
    logic two_pump;
    two_pump = (v == VAR_TWO_PUMP_TWO_OUT) || (v == VAR_TWO_PUMP_THR_OUT) ||
               (v == VAR_TWO_PUMP_FOU_OUT);
    case (c)
      CMD_PUMP_ONE: allowed = (v == VAR_ONE_PUMP_ONE_OUT) || (v == VAR_ONE_PUMP_TWO_OUT) ||
                              (v == VAR_TWO_PUMP_TWO_OUT);
      CMD_PUMP_TWO,
      CMD_BOTH:     allowed = two_pump;
      CMD_FILL,
      CMD_ACK:      allowed = 1'b1;
      default:      allowed = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  plcd_state_t      state_r;
  plcd_state_t      state_nxt;
  plcd_cmd_t        cmd;
  logic             meas_rise;
  logic             meas_fall;
  logic [LEN_W-1:0] meas_len;
  logic             armed_r;
  logic             take;
  logic [DIV_W-1:0] div_r;
  logic             tick;
  logic [LEN_W-1:0] tmr_r;
  logic [LEN_W-1:0] phase_r;
  logic             fast_r;
  logic             slow_r;

  // ----------------------------------------------------------------------
  // measurement
  // ----------------------------------------------------------------------
  plcd_pulse_meter #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_meter (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RESET_N),
    .i_level (I_CMD_LINE),
    .o_rise  (meas_rise),
    .o_fall  (meas_fall),
    .o_len   (meas_len)
  );

  assign cmd  = classify(meas_len);
  assign take = meas_fall && armed_r && allowed(cmd, I_VARIANT);

  // only pulses begun while listening count
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      armed_r <= 1'b0;
    end else if (meas_rise) begin
      armed_r <= (state_r == ST_IDLE) || (state_r == ST_ERROR);
    end else if (meas_fall || !((state_r == ST_IDLE) || (state_r == ST_ERROR))) begin
      armed_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // timebase for state timers and blink patterns
  // ----------------------------------------------------------------------
  assign tick = (div_r == DIV_W'(P_TICK_CYCLES - 1));

  // free running 0.1 s divider
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_r <= '0;
    end else begin
      div_r <= tick ? '0 : div_r + 1'b1;
    end
  end

  // state timer, cleared on each state change
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r) begin
      tmr_r <= '0;
    end else if (tick && tmr_r != LEN_SAT) begin
      tmr_r <= tmr_r + 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      phase_r <= '0;
      fast_r  <= 1'b0;
      slow_r  <= 1'b0;
    end else if (tick) begin
      phase_r <= (phase_r == SLOW_TICKS - 1'b1) ? '0 : phase_r + 1'b1;
      if (phase_r == SLOW_TICKS - 1'b1) begin
        slow_r <= ~slow_r;
      end
      if (phase_r == SLOW_TICKS - 1'b1 || phase_r == FAST_TICKS - 1'b1) begin
        fast_r <= ~fast_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SELFTEST: if (tmr_r >= SELF_TICKS) begin
        state_nxt = I_SELFTEST_FAIL ? ST_ERROR : ST_GUARD;
      end
      ST_GUARD: if (tmr_r >= GUARD_TICKS) begin
        state_nxt = ST_IDLE;
      end
      // start the run on the falling edge
      ST_IDLE: if (take && cmd != CMD_ACK) begin
        state_nxt = ST_RUN;
      end
      ST_RUN: if (I_RUN_ERROR) begin
        state_nxt = ST_ERROR;
      end else if (I_RUN_DONE) begin
        state_nxt = ST_GUARD;
      end
      ST_ERROR: if (take && cmd == CMD_ACK) begin
        state_nxt = ST_GUARD;
      end
      default: state_nxt = ST_SELFTEST;
    endcase
  end

  // state register
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_r <= ST_SELFTEST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // run selection latched at the start
  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RUN_START    <= 1'b0;
      O_RUN_PUMP_ONE <= 1'b0;
      O_RUN_PUMP_TWO <= 1'b0;
      O_RUN_FILL     <= 1'b0;
    end else begin
      O_RUN_START <= (state_r == ST_IDLE) && (state_nxt == ST_RUN);
      if ((state_r == ST_IDLE) && (state_nxt == ST_RUN)) begin
        O_RUN_PUMP_ONE <= (cmd == CMD_PUMP_ONE) || (cmd == CMD_BOTH);
        O_RUN_PUMP_TWO <= (cmd == CMD_PUMP_TWO) || (cmd == CMD_BOTH);
        O_RUN_FILL     <= (cmd == CMD_FILL);
      end else if (state_r != ST_RUN) begin
        O_RUN_PUMP_ONE <= 1'b0;
        O_RUN_PUMP_TWO <= 1'b0;
        O_RUN_FILL     <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_ERROR_ACK <= 1'b0;
    end else begin
      O_ERROR_ACK <= take && (cmd == CMD_ACK) &&
                     ((state_r == ST_IDLE) || (state_r == ST_ERROR));
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_STATUS <= 1'b0;
    end else begin
      case (state_r)
        ST_SELFTEST: O_STATUS <= 1'b0;
        ST_GUARD,
        ST_IDLE:     O_STATUS <= I_CARTRIDGE_EMPTY ? slow_r : 1'b1;
        ST_RUN:      O_STATUS <= 1'b0;
        ST_ERROR:    O_STATUS <= fast_r;
        default:     O_STATUS <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_idle_fall(plcd_cmd_t c);
    state_r == ST_IDLE && meas_fall && armed_r && cmd == c && allowed(c, I_VARIANT);
  endsequence

  a_pump_one_decode: assert property (s_idle_fall(CMD_PUMP_ONE) |=>
    O_RUN_START && O_RUN_PUMP_ONE && !O_RUN_PUMP_TWO)
    else $error("pump one pulse did not start pump one");
  a_fill_decode: assert property (s_idle_fall(CMD_FILL) |=>
    O_RUN_START && O_RUN_FILL ##1 state_r == ST_RUN)
    else $error("fill pulse did not start fill");
  a_ack_decode: assert property (state_r == ST_ERROR && take && cmd == CMD_ACK |=>
    O_ERROR_ACK && state_r == ST_GUARD)
    else $error("acknowledge pulse not taken");
  a_off_window: assert property (meas_fall && cmd == CMD_NONE |=>
    $stable(state_r) && !O_RUN_START && !O_ERROR_ACK)
    else $error("out of window pulse caused action");
  a_overlong_ignored: assert property (meas_fall && meas_len > LIMIT_TICKS |=>
    !O_RUN_START && !O_ERROR_ACK)
    else $error("overlong pulse caused action");
  a_selftest_first: assert property ($rose(I_RESET_N) |-> state_r == ST_SELFTEST)
    else $error("did not begin in self-check");
  a_variant_gate: assert property (O_RUN_START && O_RUN_PUMP_TWO |->
    I_VARIANT inside {VAR_TWO_PUMP_TWO_OUT, VAR_TWO_PUMP_THR_OUT, VAR_TWO_PUMP_FOU_OUT})
    else $error("pump two run in one pump variant");
  a_empty_pattern: assert property (state_r == ST_IDLE && I_CARTRIDGE_EMPTY |=>
    O_STATUS == $past(slow_r))
    else $error("empty cartridge pattern wrong");
  a_ready_high: assert property (state_r == ST_IDLE && !I_CARTRIDGE_EMPTY |=> O_STATUS)
    else $error("status not high while ready");
  a_run_low: assert property (state_r == ST_RUN [*2] |-> !O_STATUS)
    else $error("status high during run");
  a_guard_deaf: assert property (state_r == ST_GUARD && meas_fall |=>
    !O_RUN_START && state_r != ST_RUN)
    else $error("command taken in hold-off");
  a_run_at_fall: assert property ($rose(O_RUN_START) |-> $past(meas_fall))
    else $error("run started away from a falling edge");

endmodule

// ===== design/plcd_pkg.sv
// constants and types of the pulse length command decoder
// assumes a single 10 MHz clock; all times are measured in 0.1 s ticks
package plcd_pkg;

  // ----------------------------------------------------------------------
  // clock and timebase
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_MS       = 100;
  localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DIV_W         = 24;
  localparam int LEN_W         = 8;

  // ----------------------------------------------------------------------
  // command lengths and tolerance
  // ----------------------------------------------------------------------
  localparam int PUMP_ONE_S  = 2;
  localparam int PUMP_TWO_S  = 5;
  localparam int BOTH_S      = 8;
  localparam int FILL_S      = 12;
  localparam int ACK_S       = 14;
  localparam int LIMIT_S     = 15;
  localparam int TOL_MS      = 100;
  localparam int GUARD_MS    = 3000;
  localparam int SELFTEST_MS = 500;
  localparam int FAST_MS     = 500;
  localparam int SLOW_MS     = 1000;

  localparam logic [LEN_W-1:0] NOM_PUMP_ONE = LEN_W'(PUMP_ONE_S * 1000 / TICK_MS);
  localparam logic [LEN_W-1:0] NOM_PUMP_TWO = LEN_W'(PUMP_TWO_S * 1000 / TICK_MS);
  localparam logic [LEN_W-1:0] NOM_BOTH     = LEN_W'(BOTH_S * 1000 / TICK_MS);
  localparam logic [LEN_W-1:0] NOM_FILL     = LEN_W'(FILL_S * 1000 / TICK_MS);
  localparam logic [LEN_W-1:0] NOM_ACK      = LEN_W'(ACK_S * 1000 / TICK_MS);
  localparam logic [LEN_W-1:0] LIMIT_TICKS  = LEN_W'(LIMIT_S * 1000 / TICK_MS);
  localparam logic [LEN_W-1:0] TOL_TICKS    = LEN_W'(TOL_MS / TICK_MS);
  // strictly more than 3 s, so one tick beyond
  localparam logic [LEN_W-1:0] GUARD_TICKS  = LEN_W'(GUARD_MS / TICK_MS + 1);
  localparam logic [LEN_W-1:0] SELF_TICKS   = LEN_W'(SELFTEST_MS / TICK_MS);
  localparam logic [LEN_W-1:0] FAST_TICKS   = LEN_W'(FAST_MS / TICK_MS);
  localparam logic [LEN_W-1:0] SLOW_TICKS   = LEN_W'(SLOW_MS / TICK_MS);
  localparam logic [LEN_W-1:0] LEN_SAT      = 8'hff;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_SELFTEST = 5'h01,
    ST_GUARD    = 5'h02,
    ST_IDLE     = 5'h04,
    ST_RUN      = 5'h08,
    ST_ERROR    = 5'h10
  } plcd_state_t;

  typedef enum logic [2:0] {
    CMD_NONE     = 3'h0,
    CMD_PUMP_ONE = 3'h1,
    CMD_PUMP_TWO = 3'h2,
    CMD_BOTH     = 3'h3,
    CMD_FILL     = 3'h4,
    CMD_ACK      = 3'h5
  } plcd_cmd_t;

  // product variants: pump bodies / outlets
  typedef enum logic [2:0] {
    VAR_ONE_PUMP_ONE_OUT = 3'h0,
    VAR_ONE_PUMP_TWO_OUT = 3'h1,
    VAR_TWO_PUMP_TWO_OUT = 3'h2,
    VAR_TWO_PUMP_THR_OUT = 3'h3,
    VAR_TWO_PUMP_FOU_OUT = 3'h4
  } plcd_variant_t;

endpackage

// ===== design/plcd_pulse_meter.sv
// high time meter for the command line, in 0.1 s ticks
// assumes i_level is already synchronous to i_clk
`timescale 1ns/10ps
module plcd_pulse_meter
  import plcd_pkg::*;
#(
  parameter int P_TICK_CYCLES = TICK_CYCLES
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_level,
  output logic                  o_rise,
  output logic                  o_fall,
  output logic [LEN_W-1:0]      o_len
);

  logic             lvl_r;
  logic [DIV_W-1:0] div_r;
  logic [LEN_W-1:0] len_r;
  logic             tick;

  // edge detect
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lvl_r <= 1'b0;
    end else begin
      lvl_r <= i_level;
    end
  end

  assign o_rise = i_level & ~lvl_r;
  assign o_fall = ~i_level & lvl_r;
  assign tick   = (div_r == DIV_W'(P_TICK_CYCLES - 1));

  // tick divider, restarted by each rising edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= '0;
    end else if (o_rise || tick) begin
      div_r <= '0;
    end else if (lvl_r) begin
      div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      len_r <= '0;
    end else if (o_rise) begin
      len_r <= '0;
    end else if (lvl_r && tick && len_r != LEN_SAT) begin
      len_r <= len_r + 1'b1; // saturates far above the 15 s limit
    end
  end

  assign o_len = len_r;

endmodule

// ===== verification/plcd_plc_model.sv
// controller model: drives the command line with timed high pulses
// assumes the bench calls send() and keeps the pauses between commands
`timescale 1ns/10ps
module plcd_plc_model (
  input  wire logic i_clk,
  output logic      o_cmd
);
  // ----------------------------------------------------------------
  // command line, low between commands
  // ----------------------------------------------------------------
  initial o_cmd = 1'b0;

  // timed high level
  // high for cyc rising edges, changed just after an edge
  task automatic send(input int cyc);
    @(posedge i_clk);
    #1 o_cmd = 1'b1;
    repeat (cyc) @(posedge i_clk);
    #1 o_cmd = 1'b0;
  endtask
endmodule

// ===== verification/tb_top.sv
// self-checking bench of the pulse length command decoder
// assumes a tick of 4 clocks so that second-long pulses stay short
`timescale 1ns/10ps
module tb_top;
  import plcd_pkg::*;
  localparam int T = 4;
  logic       clk, rst_n, cmd, st_fail, empty, done, err;
  logic [2:0] variant;
  logic       status, run_start, p1, p2, fill, ack;
  int         fail_count, total_checks;
  int         noms[5] = '{int'(NOM_PUMP_ONE), int'(NOM_PUMP_TWO), int'(NOM_BOTH),
                          int'(NOM_FILL), int'(NOM_ACK)};
  int         rejects[6] = '{17, 24, 45, 100, 160, 175};
  int         gaps[5] = '{220, 250, 450, 35, 35}; // command to command pause, in ticks

  plcd_decoder #(.P_TICK_CYCLES(T)) dut_u (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_CMD_LINE(cmd), .I_VARIANT(variant),
    .I_SELFTEST_FAIL(st_fail), .I_CARTRIDGE_EMPTY(empty), .I_RUN_DONE(done),
    .I_RUN_ERROR(err), .O_STATUS(status), .O_RUN_START(run_start),
    .O_RUN_PUMP_ONE(p1), .O_RUN_PUMP_TWO(p2), .O_RUN_FILL(fill), .O_ERROR_ACK(ack)
  );
  plcd_plc_model plc_u (.i_clk(clk), .o_cmd(cmd));

  // ----------------------------------------------------------------
  // clock, compare and closing report
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // reference model: {start, pump one, pump two, fill, ack}
  // ----------------------------------------------------------------
  function automatic bit near(input int len, input int nom);
    return len >= nom - int'(TOL_TICKS) && len <= nom + int'(TOL_TICKS);
  endfunction

  function automatic logic [4:0] model(input int h, input int v);
    int len;
    logic [4:0] r;
    len = (h - 1) / T;
    r = 5'h00;
    if (near(len, noms[0]) && v <= 2) r = 5'h18;
    if (near(len, noms[1]) && v >= 2) r = 5'h14;
    if (near(len, noms[2]) && v >= 2) r = 5'h1c;
    if (near(len, noms[3])) r = 5'h12;
    if (near(len, noms[4])) r = 5'h01;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------
  task automatic do_reset(input logic bad);
    rst_n = 1'b0;
    st_fail = bad;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #2 check("selftest_status", status, 1'b0);
    repeat (40 * T) @(posedge clk);
    #1 st_fail = 1'b0;
  endtask

  // pulse of h high cycles, outputs looked at on the two edges after the fall
  task automatic fire(input int h, input logic [4:0] exp, input logic chk_st);
    plc_u.send(h);
    @(posedge clk);
    #2 check("decode", {run_start, p1, p2, fill, ack}, exp);
    @(posedge clk);
    #2 check("one_cycle_pulses", {run_start, ack}, 2'b00);
    if (chk_st) check("status_after", status, !exp[4]);
  endtask

  // motor side answers done or error, levels checked before and after
  task automatic end_run(input logic bad, input logic [4:0] exp);
    repeat (3 * T) @(posedge clk);
    #2 check("run_levels", {status, p1, p2, fill}, {1'b0, exp[3:1]});
    @(posedge clk);
    #1 {done, err} = bad ? 2'b01 : 2'b10;
    @(posedge clk);
    #1 {done, err} = 2'b00;
    @(posedge clk);
    #2 check("levels_clear", {p1, p2, fill}, 3'h0);
    if (!bad) check("status_done", status, 1'b1);
  endtask

  task automatic blink(input string what, input int lo, input int hi);
    int n;
    logic last;
    n = 0;
    last = status;
    repeat (200) begin
      @(posedge clk);
      #2;
      if (status !== last) n++;
      last = status;
    end
    check(what, {7'h00, (n >= lo && n <= hi)}, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int h;
    logic [4:0] e;
    rst_n = 1'b0;
    variant = 3'h4;
    st_fail = 1'b0;
    empty = 1'b0;
    done = 1'b0;
    err = 1'b0;
    fail_count = 0;
    total_checks = 0;
    void'($urandom(97467));
    do_reset(1'b0);
    blink("ready_steady", 0, 0);
    check("ready_level", status, 1'b1);
    // every command in every variant, length jittered by a cycle
    // first command after standstill is a single stroke
    for (int v = 0; v < 5; v++) begin
      #1 variant = v[2:0];
      foreach (noms[i]) begin
        h = noms[i] * T + int'($urandom_range(2)) - 1;
        e = model(h, v);
        fire(h, e, 1'b1);
        if (e[4]) end_run(1'b0, e);
        repeat (gaps[i] * T) @(posedge clk);
      end
    end
    // lengths outside every window and beyond the limit
    foreach (rejects[i]) fire(rejects[i] * T, model(rejects[i] * T, 4), 1'b1);
    // pulses while running and in the pause after a run
    variant = 3'h1;
    fire(noms[0] * T, 5'h18, 1'b1);
    plc_u.send(noms[0] * T);
    @(posedge clk);
    #2 check("busy_ignored", {run_start, ack}, 2'b00);
    end_run(1'b0, 5'h18);
    fire(noms[0] * T, 5'h00, 1'b1);
    repeat (35 * T) @(posedge clk);
    // failed fill run, error state and acknowledgement
    #1 variant = 3'h4;
    fire(noms[3] * T, 5'h12, 1'b1);
    end_run(1'b1, 5'h12);
    blink("error_blink", 9, 11);
    fire(noms[1] * T, 5'h00, 1'b0);
    fire(noms[4] * T, 5'h01, 1'b1);
    repeat (35 * T) @(posedge clk);
    // empty cartridge while ready
    #1 empty = 1'b1;
    blink("empty_blink", 4, 6);
    empty = 1'b0;
    // self-check failure after a second reset
    do_reset(1'b1);
    blink("selftest_blink", 9, 11);
    fire(noms[4] * T, 5'h01, 1'b1);
    wrap_up();
  end

  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    $display("BAD watchdog expected done seen hang");
    wrap_up();
  end
endmodule
